// ==== bench/irq_enable_bank_assertions.sv ====
`timescale 1ns/1ps
// Gating and enable-write checks seen only from the top ports
module irq_enable_bank_assertions
  import irq_bank_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst_b,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic              wr_en,
  input wire logic              global_peripheral_irq_enable,
  input wire logic              oscillator_fail_req,
  input wire logic              comparator_two_req,
  input wire logic              comparator_one_req,
  input wire logic              nv_write_done_req,
  input wire logic              serial_bus_collision_req,
  input wire logic              comparator_four_req,
  input wire logic              comparator_three_req,
  input wire logic              capture_compare_two_req,
  input wire logic [DATA_W-1:0] peripheral_interrupt_enable_1,
  input wire logic              peripheral_irq
);
  logic [7:0] req;
  logic [7:0] en;
  logic       glob;
  // Requests gathered in enable-bank bit order
  assign req = {oscillator_fail_req, comparator_two_req, comparator_one_req,
                nv_write_done_req, serial_bus_collision_req,
                comparator_four_req, comparator_three_req,
                capture_compare_two_req};
  assign en = peripheral_interrupt_enable_1;
  assign glob = global_peripheral_irq_enable;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  AST_GLOBAL_GATE: assert property (
    !glob |=> !peripheral_irq) else $error("irq without global enable");
  AST_CMP_ONE_PASS: assert property (
    req[5] && en[5] && glob |=> peripheral_irq) else $error("bit 5 lost");
  AST_CMP_THREE_PASS: assert property (
    req[1] && en[1] && glob |=> peripheral_irq) else $error("bit 1 lost");
  AST_CMP_THREE_BLOCK: assert property (
    req == 8'h02 && !en[1] |=> !peripheral_irq) else $error("bit 1 leak");
  AST_ANY_BLOCK: assert property (
    (req & en) == 8'h00 |=> !peripheral_irq) else $error("masked leak");
  AST_ENABLE_WRITE: assert property (
    wr_en && addr == OFS_ENABLE |=> en == $past(wr_data))
    else $error("enable write lost");
endmodule

bind irq_enable_bank irq_enable_bank_assertions chk (.clock, .rst_b, .addr,
  .wr_data, .wr_en, .global_peripheral_irq_enable, .oscillator_fail_req,
  .comparator_two_req, .comparator_one_req, .nv_write_done_req,
  .serial_bus_collision_req, .comparator_four_req, .comparator_three_req,
  .capture_compare_two_req, .peripheral_interrupt_enable_1, .peripheral_irq);

// ==== bench/tb_irq_enable_bank.sv ====
`timescale 1ns/1ps
module tb_irq_enable_bank
  import irq_bank_pkg::*;
;
  logic              clock, rst_b, wr_en, rd_en, glob, g;
  logic              peripheral_irq, event_irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data, rd_data, en, req, d, en_m, r;
  int                n_errors, check_count, cyc, seed;

  irq_enable_bank dut (.clock, .rst_b, .addr, .wr_data, .wr_en, .rd_en,
    .rd_data, .global_peripheral_irq_enable(glob),
    .oscillator_fail_req(req[7]), .comparator_two_req(req[6]),
    .comparator_one_req(req[5]), .nv_write_done_req(req[4]),
    .serial_bus_collision_req(req[3]), .comparator_four_req(req[2]),
    .comparator_three_req(req[1]), .capture_compare_two_req(req[0]),
    .peripheral_interrupt_enable_1(en), .peripheral_irq, .event_irq);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    // Shadow of the enable bank, kept apart from the design's outputs
    if (a == OFS_ENABLE) begin
      en_m = v;
    end
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 chk(rd_data, exp);
  endtask

  // Expected request: enabled sources, all blocked when global is low
  function automatic logic [7:0] gate(input logic [7:0] r, e, input logic g);
    return g ? (r & e) : 8'h00;
  endfunction

  task automatic drive(input logic [7:0] r, input logic g);
    @(posedge clock);
    req <= r;
    glob <= g;
    @(posedge clock);
    #1 chk({7'h00, peripheral_irq}, {7'h00, |gate(r, en_m, g)});
    chk(en, en_m);
  endtask

  task automatic evt(input logic exp);
    repeat (2) @(posedge clock);
    #1 chk({7'h00, event_irq}, {7'h00, exp});
  endtask

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      close_out;
    end
  end

  initial begin
    seed = 32'h4966_6e3a;
    {rst_b, wr_en, rd_en, glob, addr, wr_data, req} = '0;
    {n_errors, check_count, cyc} = '0;
    en_m = RST_ENABLE;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    chk(en, RST_ENABLE);
    chk(rd_data, RST_ZERO);
    chk({7'h00, peripheral_irq}, 8'h00);
    chk({7'h00, event_irq}, 8'h00);
    rd(OFS_ENABLE, 8'h00);
    $display("reset test done");
    wr(OFS_ENABLE, 8'h20);
    drive(8'h20, 1'b1);
    drive(8'hDF, 1'b1);
    drive(8'h20, 1'b0);
    wr(OFS_ENABLE, 8'h02);
    drive(8'h02, 1'b1);
    wr(OFS_ENABLE, 8'hFD);
    drive(8'h02, 1'b1);
    drive(8'hFF, 1'b0);
    $display("corner test done");
    // Each source alone, then every other source against it
    for (int i = 0; i < 8; i++) begin
      wr(OFS_ENABLE, 8'h01 << i);
      drive(8'h01 << i, 1'b1);
      drive(~(8'h01 << i), 1'b1);
    end
    for (int i = 0; i < 60; i++) begin
      d = 8'($random(seed));
      wr(OFS_ENABLE, d);
      rd(OFS_ENABLE, d);
      r = 8'($random(seed));
      g = 1'($random(seed));
      drive(r, g);
      rd(OFS_PENDING, gate(r, en_m, g));
    end
    // Mid-run reset must clear the bank whatever it held
    @(posedge clock);
    rst_b <= 1'b0;
    @(posedge clock);
    #1 chk(en, RST_ENABLE);
    chk(rd_data, RST_ZERO);
    chk({7'h00, peripheral_irq}, 8'h00);
    en_m = RST_ENABLE;
    @(posedge clock);
    rst_b <= 1'b1;
    rd(OFS_ENABLE, RST_ENABLE);
    $display("random test done");
    // Quiet requests first so the raise below is a true rising edge
    drive(8'h00, 1'b1);
    wr(OFS_STATUS, 8'hFF);
    wr(OFS_MASK, 8'h80);
    rd(OFS_MASK, 8'h80);
    drive(8'h80, 1'b0);
    evt(1'b1);
    rd(OFS_STATUS, 8'h80);
    rd(OFS_PENDING, 8'h00);
    rd(4'h2, 8'h00);
    wr(OFS_MASK, 8'h00);
    evt(1'b0);
    wr(OFS_MASK, 8'h80);
    evt(1'b1);
    drive(8'h00, 1'b0);
    wr(OFS_STATUS, 8'h80);
    evt(1'b0);
    rd(OFS_STATUS, 8'h00);
    $display("status test done");
    close_out;
  end
endmodule

// ==== hdl/irq_bank_pkg.sv ====
package irq_bank_pkg;

  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int SRC_N  = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_ENABLE  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_MASK    = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_PENDING = 4'hC;

  // Enable bank field positions, one source per bit
  localparam int POS_OSC_FAIL   = 7;
  localparam int POS_CMP_TWO    = 6;
  localparam int POS_CMP_ONE    = 5;
  localparam int POS_NV_WRITE   = 4;
  localparam int POS_BUS_COLL   = 3;
  localparam int POS_CMP_FOUR   = 2;
  localparam int POS_CMP_THREE  = 1;
  localparam int POS_CCP_TWO    = 0;

  // Reset values
  localparam logic [DATA_W-1:0] RST_ENABLE = 8'h00;
  localparam logic [DATA_W-1:0] RST_STATUS = 8'h00;
  localparam logic [DATA_W-1:0] RST_MASK   = 8'h00;
  localparam logic [DATA_W-1:0] RST_ZERO   = 8'h00;

endpackage

// ==== hdl/irq_enable_bank.sv ====
`timescale 1ns/1ps
// Function
// - Nothing reaches peripheral_irq without global peripheral enable
// - Bit 5 gates comparator one request
// - Bit 1 set passes comparator three
// - Bit 1 clear blocks comparator three
module irq_enable_bank
  import irq_bank_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rd_data,
  input  wire logic              global_peripheral_irq_enable,
  input  wire logic              oscillator_fail_req,
  input  wire logic              comparator_two_req,
  input  wire logic              comparator_one_req,
  input  wire logic              nv_write_done_req,
  input  wire logic              serial_bus_collision_req,
  input  wire logic              comparator_four_req,
  input  wire logic              comparator_three_req,
  input  wire logic              capture_compare_two_req,
  output logic      [DATA_W-1:0] peripheral_interrupt_enable_1,
  output logic                   peripheral_irq,
  output logic                   event_irq
);

  // Enable bank, the software-written register
  logic [DATA_W-1:0] enable_r;
  logic [DATA_W-1:0] enable_nxt;

  // Event mask for the sticky status bank
  logic [DATA_W-1:0] mask_r;
  logic [DATA_W-1:0] mask_nxt;

  // Read data port, valid only the cycle after the strobe
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] rd_data_nxt;

  // Outgoing request lines
  logic              periph_irq_r;
  logic              periph_irq_nxt;
  logic              event_irq_r;
  logic              event_irq_nxt;

  // Source requests gathered into the bank's bit order
  logic [SRC_N-1:0]  req_vec;
  logic [SRC_N-1:0]  gated_vec;
  logic [SRC_N-1:0]  pending_vec;
  logic [SRC_N-1:0]  rise_vec;
  logic [SRC_N-1:0]  status_vec;

  // Address decode results
  logic              hit_enable;
  logic              hit_status;
  logic              hit_mask;
  logic              hit_pending;

  // Place each source at its own bit of the bank
  // remaining source order
  always_comb begin
    req_vec                = '0;
    req_vec[POS_OSC_FAIL]  = oscillator_fail_req;
    req_vec[POS_CMP_TWO]   = comparator_two_req;
    req_vec[POS_CMP_ONE]   = comparator_one_req;
    req_vec[POS_NV_WRITE]  = nv_write_done_req;
    req_vec[POS_BUS_COLL]  = serial_bus_collision_req;
    req_vec[POS_CMP_FOUR]  = comparator_four_req;
    req_vec[POS_CMP_THREE] = comparator_three_req;
    req_vec[POS_CCP_TWO]   = capture_compare_two_req;
  end

  // Per-source gate: a request only counts where its enable bit is one.
  // A clear bit blocks the request but never touches the source's flag.
  for (genvar i = 0; i < SRC_N; i++) begin : g_gate
    assign gated_vec[i] = req_vec[i] & enable_r[i];
  end

  // Global enable sits after the per-bit gates
  // global enable gate
  assign pending_vec = global_peripheral_irq_enable ? gated_vec : '0;

  // Rising edges of the raw requests feed the sticky status bank
  source_edge #(
    .W        (SRC_N)
  ) u_edge (
    .clock    (clock),
    .rst_b    (rst_b),
    .level_in (req_vec),
    .rise     (rise_vec)
  );

  // Sticky status, cleared by writing ones at its offset
  sticky_status #(
    .W        (SRC_N)
  ) u_status (
    .clock    (clock),
    .rst_b    (rst_b),
    .set_in   (rise_vec),
    .clr_we   (wr_en & hit_status),
    .clr_data (wr_data),
    .status   (status_vec)
  );

  // Address decode; unmapped addresses hit nothing
  always_comb begin
    hit_enable  = 1'b0;
    hit_status  = 1'b0;
    hit_mask    = 1'b0;
    hit_pending = 1'b0;
    if (addr == OFS_ENABLE) begin
      hit_enable = 1'b1;
    end else if (addr == OFS_STATUS) begin
      hit_status = 1'b1;
    end else if (addr == OFS_MASK) begin
      hit_mask = 1'b1;
    end else if (addr == OFS_PENDING) begin
      hit_pending = 1'b1;
    end
  end

  // Enable bank write path; every bit is plain read/write
  // all bits writable
  always_comb begin
    enable_nxt = enable_r;
    if (wr_en && hit_enable) begin
      enable_nxt = wr_data;
    end
  end

  // Mask write path
  always_comb begin
    mask_nxt = mask_r;
    if (wr_en && hit_mask) begin
      mask_nxt = wr_data;
    end
  end

  // Read mux; returns zero outside a read so stale data never lingers
  always_comb begin
    rd_data_nxt = RST_ZERO;
    if (rd_en) begin
      if (hit_enable) begin
        rd_data_nxt = enable_r;
      end else if (hit_status) begin
        rd_data_nxt = status_vec;
      end else if (hit_mask) begin
        rd_data_nxt = mask_r;
      end else if (hit_pending) begin
        rd_data_nxt = pending_vec;
      end
    end
  end

  // Request to the processor: any enabled source while global is set.
  // Registered for a clean output, at the cost of one cycle of latency.
  // no pass without global
  always_comb begin
    periph_irq_nxt = |pending_vec;
  end

  // Event interrupt: level while any unmasked sticky bit stands
  always_comb begin
    event_irq_nxt = |(status_vec & mask_r);
  end

  // Register stage for enable, mask, read data and both request outputs
  // bank resets to zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      enable_r     <= RST_ENABLE;
      mask_r       <= RST_MASK;
      rd_data_r    <= RST_ZERO;
      periph_irq_r <= 1'b0;
      event_irq_r  <= 1'b0;
    end else begin
      enable_r     <= enable_nxt;
      mask_r       <= mask_nxt;
      rd_data_r    <= rd_data_nxt;
      periph_irq_r <= periph_irq_nxt;
      event_irq_r  <= event_irq_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign rd_data                       = rd_data_r;
  assign peripheral_interrupt_enable_1 = enable_r;
  assign peripheral_irq                = periph_irq_r;
  assign event_irq                     = event_irq_r;

endmodule

// ==== hdl/source_edge.sv ====
`timescale 1ns/1ps
module source_edge
  import irq_bank_pkg::*;
#(
  parameter int W = SRC_N
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] level_in,
  output logic      [W-1:0] rise
);

  logic [W-1:0] prev_r;
  logic [W-1:0] prev_nxt;

  // Per-source history bit and rising-edge pulse
  for (genvar i = 0; i < W; i++) begin : g_src
    always_comb begin
      prev_nxt[i] = level_in[i];
      rise[i]     = level_in[i] & ~prev_r[i];
    end
  end

  // History starts low, so a level high out of reset counts once
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= '0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

endmodule

// ==== hdl/sticky_status.sv ====
`timescale 1ns/1ps
module sticky_status
  import irq_bank_pkg::*;
#(
  parameter int W = SRC_N
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] set_in,
  input  wire logic         clr_we,
  input  wire logic [W-1:0] clr_data,
  output logic      [W-1:0] status
);

  logic [W-1:0] status_r;
  logic [W-1:0] status_nxt;

  // Write one to clear; a set in the same cycle wins so no event is lost
  always_comb begin
    status_nxt = status_r;
    if (clr_we) begin
      status_nxt = status_nxt & ~clr_data;
    end
    status_nxt = status_nxt | set_in;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= W'(RST_STATUS);
    end else begin
      status_r <= status_nxt;
    end
  end

  assign status = status_r;

endmodule
